/* rtl/kio_debounce.sv */
`timescale 1ns/1ps
`default_nettype none

module kio_debounce #(
    parameter int N = 18
) (
    // Debounce clock and reset.
    input  wire logic debClk,
    input  wire logic reset,
    // Lines.
    kio_lines_if.deb  lines
);

    // ==========================================================
    // Reset and pin synchronisers.
    logic         rstS1_q;
    logic         rstS2_q;
    logic [N-1:0] pinS1_q;
    logic [N-1:0] pinS2_q;
    logic [N-1:0] stage1_q;
    logic [N-1:0] stage2_q;

    always_ff @(posedge debClk) begin
        rstS1_q <= reset;
        rstS2_q <= rstS1_q;
    end

    always_ff @(posedge debClk) begin
        if (rstS2_q) begin
            pinS1_q <= kio_pkg::LINE_RST[N-1:0];
            pinS2_q <= kio_pkg::LINE_RST[N-1:0];
        end else begin
            pinS1_q <= lines.raw;
            pinS2_q <= pinS1_q;
        end
    end

    // ==========================================================
    // Two-stage debounce per line.
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            always_ff @(posedge debClk) begin
                if (rstS2_q) begin
                    stage1_q[i] <= kio_pkg::LINE_RST[i];
                    stage2_q[i] <= kio_pkg::LINE_RST[i];
                end else begin
                    stage1_q[i] <= pinS2_q[i];
                    if (pinS2_q[i] == stage1_q[i]) begin
                        stage2_q[i] <= stage1_q[i];
                    end
                end
            end
        end
    endgenerate

    assign lines.clean = stage2_q;

endmodule : kio_debounce

`default_nettype wire

/* rtl/kio_lines_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface kio_lines_if #(
    parameter int N = 18
);
    logic [N-1:0] raw;
    logic [N-1:0] clean;

    modport deb  (input raw, output clean);
    modport core (output raw, input clean);
endinterface : kio_lines_if

`default_nettype wire

/* rtl/kio_pkg.sv */
package kio_pkg;

    // ==========================================================
    // Line layout and serial address.
    localparam int          NUM_ROWS    = 8;
    localparam int          NUM_COLS    = 10;
    localparam int          NUM_LINES   = 18;
    localparam logic [6:0]  SLAVE_ADDR  = 7'h34;
    localparam logic [17:0] COL_MASK    = 18'h3ff00;

    // ==========================================================
    // Register pointers of the input ports.
    localparam logic [7:0]  PTR_ROW     = 8'h14;
    localparam logic [7:0]  PTR_COL_LO  = 8'h15;
    localparam logic [7:0]  PTR_COL_HI  = 8'h16;

    // ==========================================================
    // Reset values.
    localparam logic [17:0] LINE_RST    = 18'h3ffff;
    localparam logic [7:0]  PTR_RST     = 8'h00;

    // ==========================================================
    // Timing.
    localparam int          REF_CLK_HZ     = 20000000;
    localparam int          INT_GAP_US     = 50;
    localparam int          INT_GAP_CYCLES = INT_GAP_US * (REF_CLK_HZ / 1000000);

    // ==========================================================
    // Serial slave states.
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } kio_state_t;

endpackage : kio_pkg

/* rtl/kio_top.sv */
`timescale 1ns/1ps
`default_nettype none

module kio_top #(
    parameter int NUM_ROWS  = kio_pkg::NUM_ROWS,
    parameter int NUM_COLS  = kio_pkg::NUM_COLS
) (
    // Clocks and reset.
    input  wire logic                     ref_clk,
    input  wire logic                     debClk,
    input  wire logic                     reset,
    // Serial bus.
    input  wire logic                     sclIn,
    input  wire logic                     sdaIn,
    output logic                          sdaOut,
    output logic                          sdaOe,
    // Row lines.
    input  wire logic [NUM_ROWS-1:0]      rowIn,
    output logic      [NUM_ROWS-1:0]      rowOut,
    output logic      [NUM_ROWS-1:0]      rowOe,
    output logic      [NUM_ROWS-1:0]      rowPullEn,
    // Column lines.
    input  wire logic [NUM_COLS-1:0]      colIn,
    output logic      [NUM_COLS-1:0]      colOut,
    output logic      [NUM_COLS-1:0]      colOe,
    output logic      [NUM_COLS-1:0]      colPullEn,
    // Configuration.
    input  wire logic                     cfgValid,
    input  wire logic [17:0]              lineIsOutput,
    input  wire logic [17:0]              lineIsKeypad,
    input  wire logic [17:0]              lineOutData,
    input  wire logic                     intPulseCfg,
    // Host side.
    output logic                          intOut,
    output logic                          intOe,
    output logic      [7:0]               regPointer,
    output logic      [7:0]               wrData,
    output logic                          wrValid
);

    localparam int NL = kio_pkg::NUM_LINES;

    // ==========================================================
    // Elaboration checks.
    if (NUM_ROWS != kio_pkg::NUM_ROWS || NUM_COLS != kio_pkg::NUM_COLS) begin : g_chk
        $error("Line counts must match the port register layout.");
    end

    // ==========================================================
    // Declarations.
    kio_pkg::kio_state_t state_q;
    logic [7:0]          shift_q;
    logic [3:0]          bitCnt_q;
    logic                rw_q;
    logic                sdaOe_q;
    logic                clrPulse_q;
    logic [7:0]          ptr_q;
    logic [7:0]          wrData_q;
    logic                wrValid_q;
    logic                sclS1_q;
    logic                sclS2_q;
    logic                sclS3_q;
    logic                sdaS1_q;
    logic                sdaS2_q;
    logic                sdaS3_q;
    logic [NL-1:0]       xs1_q;
    logic [NL-1:0]       xs2_q;
    logic [NL-1:0]       snap_q;
    logic                cfgSeen_q;
    logic [10:0]         gapCnt_q;
    logic                intOe_q;
    logic [NL-1:0]       lineOe_q;
    logic [NL-1:0]       lineOut_q;
    logic [NL-1:0]       linePull_q;
    logic [NL-1:0]       lineOe_d;
    logic [NL-1:0]       lineOut_d;
    logic [NL-1:0]       linePull_d;
    logic [NL-1:0]       inEn;
    logic [NL-1:0]       mismatch;
    logic                pending;
    logic                sclRise;
    logic                sclFall;
    logic                startCond;
    logic                stopCond;
    logic [7:0]          readByte;

    kio_lines_if #(.N(NL)) lines ();

    assign lines.raw = {colIn, rowIn};

    // ==========================================================
    // Input debounce on the debounce clock.
    kio_debounce #(.N(NL)) u_deb (
        .debClk (debClk),
        .reset  (reset),
        .lines  (lines)
    );

    // ==========================================================
    // Debounced lines cross into the reference clock.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            xs1_q <= kio_pkg::LINE_RST;
            xs2_q <= kio_pkg::LINE_RST;
        end else begin
            xs1_q <= lines.clean;
            xs2_q <= xs1_q;
        end
    end

    // ==========================================================
    // Bus pin synchronisers.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclS1_q <= 1'b1;
            sclS2_q <= 1'b1;
            sclS3_q <= 1'b1;
            sdaS1_q <= 1'b1;
            sdaS2_q <= 1'b1;
            sdaS3_q <= 1'b1;
        end else begin
            sclS1_q <= sclIn;
            sclS2_q <= sclS1_q;
            sclS3_q <= sclS2_q;
            sdaS1_q <= sdaIn;
            sdaS2_q <= sdaS1_q;
            sdaS3_q <= sdaS2_q;
        end
    end

    assign sclRise   = sclS2_q & ~sclS3_q;
    assign sclFall   = ~sclS2_q & sclS3_q;
    assign startCond = sclS2_q & sclS3_q & ~sdaS2_q & sdaS3_q;
    assign stopCond  = sclS2_q & sclS3_q & sdaS2_q & ~sdaS3_q;

    // ==========================================================
    // Read data for the current pointer.
    always_comb begin
        case (ptr_q)
            kio_pkg::PTR_ROW:    readByte = xs2_q[7:0];
            kio_pkg::PTR_COL_LO: readByte = xs2_q[15:8];
            kio_pkg::PTR_COL_HI: readByte = {6'h00, xs2_q[17:16]};
            default:             readByte = 8'h00;
        endcase
    end

    // ==========================================================
    // Serial slave state machine.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q    <= kio_pkg::ST_IDLE;
            shift_q    <= 8'h00;
            bitCnt_q   <= 4'h0;
            rw_q       <= 1'b0;
            sdaOe_q    <= 1'b0;
            clrPulse_q <= 1'b0;
        end else if (startCond) begin
            state_q    <= kio_pkg::ST_ADDR;
            bitCnt_q   <= 4'h0;
            sdaOe_q    <= 1'b0;
            clrPulse_q <= 1'b0;
        end else if (stopCond) begin
            state_q    <= kio_pkg::ST_IDLE;
            sdaOe_q    <= 1'b0;
            clrPulse_q <= 1'b0;
        end else begin
            clrPulse_q <= 1'b0;
            case (state_q)
                kio_pkg::ST_ADDR, kio_pkg::ST_CMD, kio_pkg::ST_WDATA: begin
                    if (sclRise) begin
                        shift_q  <= {shift_q[6:0], sdaS2_q};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (sclFall && bitCnt_q == 4'h8) begin
                        bitCnt_q <= 4'h0;
                        if (state_q == kio_pkg::ST_ADDR) begin
                            if (shift_q[7:1] == kio_pkg::SLAVE_ADDR) begin
                                rw_q    <= shift_q[0];
                                sdaOe_q <= 1'b1;
                                state_q <= kio_pkg::ST_ADDR_ACK;
                            end else begin
                                state_q <= kio_pkg::ST_IDLE;
                            end
                        end else if (state_q == kio_pkg::ST_CMD) begin
                            sdaOe_q <= 1'b1;
                            state_q <= kio_pkg::ST_CMD_ACK;
                        end else begin
                            sdaOe_q <= 1'b1;
                            state_q <= kio_pkg::ST_WACK;
                        end
                    end
                end
                kio_pkg::ST_ADDR_ACK: begin
                    if (sclFall) begin
                        bitCnt_q <= 4'h0;
                        if (rw_q) begin
                            shift_q <= readByte;
                            sdaOe_q <= ~readByte[7];
                            state_q <= kio_pkg::ST_RDATA;
                        end else begin
                            sdaOe_q <= 1'b0;
                            state_q <= kio_pkg::ST_CMD;
                        end
                    end
                end
                kio_pkg::ST_CMD_ACK, kio_pkg::ST_WACK: begin
                    if (sclFall) begin
                        sdaOe_q <= 1'b0;
                        state_q <= kio_pkg::ST_WDATA;
                    end
                end
                kio_pkg::ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_q == 4'h8) begin
                            sdaOe_q <= 1'b0;
                            state_q <= kio_pkg::ST_RACK;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sdaOe_q <= ~shift_q[6];
                        end
                    end
                end
                kio_pkg::ST_RACK: begin
                    if (sclRise) begin
                        clrPulse_q <= 1'b1;
                        if (sdaS2_q) begin
                            state_q <= kio_pkg::ST_IDLE;
                        end
                    end else if (sclFall) begin
                        bitCnt_q <= 4'h0;
                        shift_q  <= readByte;
                        sdaOe_q  <= ~readByte[7];
                        state_q  <= kio_pkg::ST_RDATA;
                    end
                end
                kio_pkg::ST_IDLE: begin
                    sdaOe_q <= 1'b0;
                end
                default: begin
                    state_q <= kio_pkg::ST_IDLE;
                    sdaOe_q <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Register pointer and written data.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ptr_q     <= kio_pkg::PTR_RST;
            wrData_q  <= 8'h00;
            wrValid_q <= 1'b0;
        end else begin
            wrValid_q <= 1'b0;
            if (!startCond && !stopCond && sclFall && bitCnt_q == 4'h8) begin
                if (state_q == kio_pkg::ST_CMD) begin
                    ptr_q <= shift_q;
                end else if (state_q == kio_pkg::ST_WDATA) begin
                    wrData_q  <= shift_q;
                    wrValid_q <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Line configuration.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfgSeen_q <= 1'b0;
        end else if (cfgValid) begin
            cfgSeen_q <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NL; i++) begin : g_line
            localparam bit IS_COL = kio_pkg::COL_MASK[i];
            always_comb begin
                lineOe_d[i]   = 1'b0;
                lineOut_d[i]  = 1'b0;
                linePull_d[i] = 1'b1;
                inEn[i]       = 1'b1;
                if (cfgSeen_q) begin
                    linePull_d[i] = 1'b0;
                    if (lineIsKeypad[i]) begin
                        if (IS_COL) begin
                            lineOe_d[i] = ~lineOutData[i];
                            inEn[i]     = 1'b0;
                        end else begin
                            linePull_d[i] = 1'b1;
                        end
                    end else if (lineIsOutput[i]) begin
                        lineOe_d[i]  = 1'b1;
                        lineOut_d[i] = lineOutData[i];
                        inEn[i]      = 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lineOe_q   <= '0;
            lineOut_q  <= '0;
            linePull_q <= kio_pkg::LINE_RST;
        end else begin
            lineOe_q   <= lineOe_d;
            lineOut_q  <= lineOut_d;
            linePull_q <= linePull_d;
        end
    end

    // ==========================================================
    // Change detection against the stored input port value.
    assign mismatch = (xs2_q ^ snap_q) & inEn;
    assign pending  = |mismatch;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            snap_q <= kio_pkg::LINE_RST;
        end else if (clrPulse_q) begin
            case (ptr_q)
                kio_pkg::PTR_ROW:    snap_q[7:0]   <= xs2_q[7:0];
                kio_pkg::PTR_COL_LO: snap_q[15:8]  <= xs2_q[15:8];
                kio_pkg::PTR_COL_HI: snap_q[17:16] <= xs2_q[17:16];
                default:             snap_q        <= snap_q;
            endcase
        end
    end

    // ==========================================================
    // Interrupt output with optional release gap.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gapCnt_q <= 11'h000;
        end else if (clrPulse_q && intPulseCfg && intOe_q) begin
            gapCnt_q <= 11'(kio_pkg::INT_GAP_CYCLES);
        end else if (gapCnt_q != 11'h000) begin
            gapCnt_q <= gapCnt_q - 11'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            intOe_q <= 1'b0;
        end else begin
            intOe_q <= pending && (gapCnt_q == 11'h000);
        end
    end

    // ==========================================================
    // Outputs.
    assign sdaOut     = 1'b0;
    assign sdaOe      = sdaOe_q;
    assign intOut     = 1'b0;
    assign intOe      = intOe_q;
    assign regPointer = ptr_q;
    assign wrData     = wrData_q;
    assign wrValid    = wrValid_q;
    assign rowOut     = lineOut_q[7:0];
    assign rowOe      = lineOe_q[7:0];
    assign rowPullEn  = linePull_q[7:0];
    assign colOut     = lineOut_q[17:8];
    assign colOe      = lineOe_q[17:8];
    assign colPullEn  = linePull_q[17:8];

endmodule : kio_top

`default_nettype wire

/* sim/kio_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bus master on the far side.
module kio_host_model #(
    parameter int HALF = 10
) (
    input  wire logic ref_clk,
    input  wire logic sdaOe,
    output logic      sclIn,
    output logic      sdaIn
);
    logic sdaLow = 1'b0;

    initial sclIn = 1'b1;
    assign sdaIn = !(sdaLow || sdaOe); // Pull-up when released.

    task automatic half();
        repeat (HALF) @(posedge ref_clk);
        #1;
    endtask : half
    task automatic bit_io(input logic b, output logic r);
        sdaLow = !b;
        half();
        sclIn = 1'b1;
        half();
        r = sdaIn;
        sclIn = 1'b0;
        half();
    endtask : bit_io
    task automatic bus_start();
        sdaLow = 1'b0;
        half();
        sclIn = 1'b1;
        half();
        sdaLow = 1'b1;
        half();
        sclIn = 1'b0;
        half();
    endtask : bus_start
    task automatic bus_stop();
        sdaLow = 1'b1;
        half();
        sclIn = 1'b1;
        half();
        sdaLow = 1'b0;
        half();
    endtask : bus_stop
    task automatic send_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
        bit_io(1'b1, ack);
    endtask : send_byte
    task automatic recv_byte(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ackIt, r);
    endtask : recv_byte
endmodule : kio_host_model

`default_nettype wire

/* sim/kio_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Checker on the top-level ports.
module kio_monitor #(
    parameter int NUM_ROWS = 8,
    parameter int NUM_COLS = 10
) (
    // Clock and reset.
    input wire logic                ref_clk,
    input wire logic                reset,
    // Serial bus.
    input wire logic                sclIn,
    input wire logic                sdaIn,
    input wire logic                sdaOe,
    // Lines and host side.
    input wire logic [NUM_ROWS-1:0] rowOe,
    input wire logic [NUM_ROWS-1:0] rowPullEn,
    input wire logic [NUM_COLS-1:0] colOe,
    input wire logic [NUM_COLS-1:0] colPullEn,
    input wire logic                cfgValid,
    input wire logic                intOe,
    input wire logic [7:0]          regPointer,
    input wire logic                wrValid
);
    logic       sclP_q;
    logic       sdaP_q;
    logic       cfgSeen_q;
    logic       addrPh_q;
    logic [3:0] bitCnt_q;
    wire logic  startSeen = sclIn && sclP_q && !sdaIn && sdaP_q;
    wire logic  stopSeen  = sclIn && sclP_q && sdaIn && !sdaP_q;
    wire logic  sclRise   = sclIn && !sclP_q;

    always_ff @(posedge ref_clk) begin
        sclP_q <= sclIn;
        sdaP_q <= sdaIn;
    end
    always_ff @(posedge ref_clk) begin
        if (reset || startSeen) bitCnt_q <= 4'h0;
        else if (sclRise) bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) addrPh_q <= 1'b0;
        else if (startSeen) addrPh_q <= 1'b1;
        else if (sclRise && bitCnt_q == 4'h8) addrPh_q <= 1'b0;
    end
    always_ff @(posedge ref_clk) begin
        if (reset) cfgSeen_q <= 1'b0;
        else if (cfgValid) cfgSeen_q <= 1'b1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_rst_out;
        disable iff (1'b0) reset |=> !sdaOe && !intOe && !wrValid && regPointer == 8'h00;
    endproperty
    property p_rst_pull;
        disable iff (1'b0) reset |=> &rowPullEn && &colPullEn && rowOe == '0 && colOe == '0;
    endproperty
    property p_pre_cfg;
        !cfgSeen_q |-> &rowPullEn && &colPullEn && rowOe == '0 && colOe == '0;
    endproperty
    property p_sda_scl;
        $changed(sdaOe) |-> !sclIn;
    endproperty
    property p_ack_ninth;
        $rose(sdaOe) && addrPh_q |-> bitCnt_q == 4'h8;
    endproperty
    property p_ptr_slot;
        $changed(regPointer) |-> bitCnt_q == 4'h8 && !sclIn;
    endproperty
    property p_wr_pulse;
        wrValid |-> bitCnt_q == 4'h8 ##1 !wrValid;
    endproperty
    property p_stop_idle;
        stopSeen |=> !sdaOe [*8];
    endproperty

    a_rst_out:   assert property (p_rst_out) else $error("outputs not at default after reset");
    a_rst_pull:  assert property (p_rst_pull) else $error("lines not pulled inputs after reset");
    a_pre_cfg:   assert property (p_pre_cfg) else $error("lines left pulled inputs early");
    a_sda_scl:   assert property (p_sda_scl) else $error("data changed while clock high");
    a_ack_ninth: assert property (p_ack_ninth) else $error("address ack outside ninth bit");
    a_ptr_slot:  assert property (p_ptr_slot) else $error("pointer changed outside byte end");
    a_wr_pulse:  assert property (p_wr_pulse) else $error("write strobe misplaced");
    a_stop_idle: assert property (p_stop_idle) else $error("data driven after stop");

    c_write: cover property (wrValid);
    c_int:   cover property ($rose(intOe));
    c_ack:   cover property ($rose(sdaOe) && addrPh_q);
endmodule : kio_monitor

bind kio_top kio_monitor #(.NUM_ROWS(NUM_ROWS), .NUM_COLS(NUM_COLS)) i_kio_monitor (
    .ref_clk(ref_clk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
    .rowOe(rowOe), .rowPullEn(rowPullEn), .colOe(colOe), .colPullEn(colPullEn),
    .cfgValid(cfgValid), .intOe(intOe), .regPointer(regPointer), .wrValid(wrValid));

`default_nettype wire

/* sim/kio_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        ref_clk, debClk, reset, cfgValid, intPulseCfg, sclIn, sdaIn, sdaOe, intOe, wrValid;
    logic [7:0]  rowIn, rowOe, rowPullEn, regPointer, wrData;
    logic [9:0]  colIn, colOe, colOut, colPullEn;
    logic [17:0] lineIsOutput, lineIsKeypad, lineOutData = 18'h0;
    int          n_mismatch, comparisons, wrCount, lowCnt;

    kio_top i_kio_top (.ref_clk(ref_clk), .debClk(debClk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(), .sdaOe(sdaOe), .rowIn(rowIn), .rowOut(), .rowOe(rowOe), .rowPullEn(rowPullEn),
        .colIn(colIn), .colOut(colOut), .colOe(colOe), .colPullEn(colPullEn), .cfgValid(cfgValid),
        .lineIsOutput(lineIsOutput), .lineIsKeypad(lineIsKeypad), .lineOutData(lineOutData),
        .intPulseCfg(intPulseCfg), .intOut(), .intOe(intOe), .regPointer(regPointer),
        .wrData(wrData), .wrValid(wrValid));
    kio_host_model i_kio_host_model (.ref_clk(ref_clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        debClk = 1'b0;
        #37;
        forever #80 debClk = ~debClk;
    end
    always @(posedge ref_clk) begin
        if (wrValid === 1'b1) wrCount++;
        if (intOe !== 1'b1) lowCnt++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_int(input logic v, input string what);
        for (int i = 0; i < 300 && intOe !== v; i++) tick(1);
        check(what, intOe, v);
    endtask : wait_int
    task automatic do_reset();
        reset = 1'b1;
        tick(16);
        reset = 1'b0;
        tick(4);
        check("idle outputs", {sdaOe, intOe, wrValid, regPointer, rowOe, colOe}, 29'h0);
        check("pull-ups", {rowPullEn, colPullEn}, 18'h3ffff);
    endtask : do_reset
    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d);
        logic [2:0] a;
        i_kio_host_model.bus_start();
        i_kio_host_model.send_byte(8'h68, a[2]);
        i_kio_host_model.send_byte(ptr, a[1]);
        i_kio_host_model.send_byte(d, a[0]);
        i_kio_host_model.bus_stop();
        check("write acks", a, 3'h0);
    endtask : wr_reg
    task automatic rd_port(input logic [7:0] ptr, input logic [7:0] exp);
        logic [2:0] a;
        logic [7:0] d;
        i_kio_host_model.bus_start();
        i_kio_host_model.send_byte(8'h68, a[2]);
        i_kio_host_model.send_byte(ptr, a[1]);
        i_kio_host_model.bus_start();
        i_kio_host_model.send_byte(8'h69, a[0]);
        i_kio_host_model.recv_byte(1'b0, d);
        check("nack release", sdaOe, 1'b0);
        i_kio_host_model.bus_stop();
        check("read acks", a, 3'h0);
        check("port data", d, exp);
    endtask : rd_port

    task automatic t_bus();
        logic a;
        int w;
        w = wrCount;
        wr_reg(8'h14, 8'ha5);
        check("strobes", wrCount - w, 1);
        check("ptr data", {regPointer, wrData}, 16'h14a5);
        for (int k = 0; k < 2; k++) begin
            i_kio_host_model.bus_start();
            i_kio_host_model.send_byte(k ? 8'he8 : 8'h6a, a);
            i_kio_host_model.bus_stop();
            check("foreign ack", a, 1'b1);
        end
        check("foreign", {intOe, regPointer}, 9'h014);
        rd_port(8'h16, 8'h03);
        $display("bus test done");
    endtask : t_bus
    task automatic t_keypad();
        lineIsKeypad = 18'h00101;
        cfgValid = 1'b1;
        tick(4);
        check("keypad column", {colOe[0], colOut[0]}, 2'b10);
        check("keypad rows", {rowOe[1:0], rowPullEn[1:0]}, 4'b0001);
        lineOutData[8] = 1'b1;
        tick(4);
        check("col off", colOe[0], 1'b0);
        lineIsKeypad = 18'h0;
        tick(4);
        check("plain column", colOe[0], 1'b0);
        $display("keypad test done");
    endtask : t_keypad
    task automatic t_edges();
        rowIn[0] = 1'b0;
        wait_int(1'b1, "falling edge");
        rowIn[0] = 1'b1;
        wait_int(1'b0, "returned");
        rowIn[0] = 1'b0;
        wait_int(1'b1, "edge after clear");
        rd_port(8'h14, 8'hfe);
        wait_int(1'b0, "read clear");
        rowIn[0] = 1'b1;
        wait_int(1'b1, "rising edge");
        rd_port(8'h14, 8'hff);
        wait_int(1'b0, "read clear 2");
        lineIsOutput[2] = 1'b1;
        rowIn[2] = 1'b0;
        tick(100);
        check("output line quiet", intOe, 1'b0);
        lineIsOutput[2] = 1'b0;
        wait_int(1'b1, "output to input");
        rowIn[2] = 1'b1;
        wait_int(1'b0, "spurious gone");
        $display("edge test done");
    endtask : t_edges
    task automatic t_pulse();
        int n;
        intPulseCfg = 1'b1;
        colIn[0] = 1'b0;
        wait_int(1'b1, "col event");
        rowIn[3] = 1'b0;
        tick(50);
        rd_port(8'h14, 8'hf7);
        for (n = 0; n < 1200 && intOe !== 1'b1; n++) tick(1);
        check("release gap", n >= 900 && n <= 1000, 1'b1);
        intPulseCfg = 1'b0;
        rowIn[3] = 1'b1;
        tick(50);
        lowCnt = 0;
        rd_port(8'h14, 8'hff);
        check("held", lowCnt, 0);
        rd_port(8'h15, 8'hfe);
        wait_int(1'b0, "col cleared");
        $display("pulse test done");
    endtask : t_pulse

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (80000) @(posedge ref_clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        cfgValid = 1'b0;
        intPulseCfg = 1'b0;
        rowIn = 8'hff;
        colIn = 10'h3ff;
        lineIsOutput = 18'h0;
        lineIsKeypad = 18'h0;
        do_reset();
        t_bus();
        t_keypad();
        t_edges();
        t_pulse();
        wr_reg(8'h15, 8'h3c);
        cfgValid = 1'b0;
        do_reset();
        end_of_test();
    end
endmodule : tb

`default_nettype wire
